// file: inc/uart_rx_timeout_pkg.sv
package uart_rx_timeout_pkg;
   localparam int TIMEOUT_HALF_W = 8;
   localparam int FIFO_CNT_W = 7;
   localparam int PERIODIC_BIT = 6;
   localparam logic [7:0] EXT_FEATURE_RESET = 8'h00;
   localparam logic [TIMEOUT_HALF_W-1:0] TIMEOUT_HIGH_RESET = 8'h00;
   localparam logic [TIMEOUT_HALF_W-1:0] TIMEOUT_LOW_RESET = 8'h40;
   localparam logic [5:0] TRIGGER_RESET = 6'h01;
endpackage : uart_rx_timeout_pkg

// file: hdl/uart_rx_timeout.sv
// Operation
// - Reads of holding, modem or line status may disturb the timeout flag.
// - A cleared timeout rises again while receive FIFO still holds data.
// - Timeout length comes from high and low count registers.
// - Bit 6 of second extended feature register selects periodic timeout.
// - Reading the interrupt identification register clears the timeout unless an expiry sets it in the same cycle.
// - Every periodic event raises the timeout again.
// - DMA requests follow the trigger level as programmed, power of two or not.
`timescale 1ns/1ns
module uart_rx_timeout #(
   parameter int FIFO_CNT_W = uart_rx_timeout_pkg::FIFO_CNT_W
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Configuration.
   input wire logic [7:0] extFeatureRegTwo,
   input wire logic [7:0] timeoutCountHigh,
   input wire logic [7:0] timeoutCountLow,
   input wire logic [5:0] rxTriggerLevel,
   input wire logic [5:0] txTriggerLevel,
   // Receive path state and transmit FIFO space.
   input wire logic rxCharStrobe,
   input wire logic [FIFO_CNT_W-1:0] rxFifoLevel,
   input wire logic [FIFO_CNT_W-1:0] txFifoSpace,
   // Register read strobes.
   input wire logic rxHoldingRegRead,
   input wire logic modemStatusRegRead,
   input wire logic lineStatusRegRead,
   input wire logic irqIdentRegRead,
   // Results.
   output logic rxTimeoutIrq,
   output logic rxDmaReq,
   output logic txDmaReq
);
   logic [15:0] limit;
   logic periodicMode;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic expire;
   logic dataWaiting;
   logic sideRead;
   logic irq_d;
   logic irq_q;
   logic [2*FIFO_CNT_W-1:0] fillPair;
   logic [11:0] trigPair;
   wire [1:0] dmaRawVec;
   wire [1:0] dmaReqVec;

   assign limit = {timeoutCountHigh, timeoutCountLow};
   assign periodicMode = extFeatureRegTwo[uart_rx_timeout_pkg::PERIODIC_BIT];
   assign dataWaiting = rxFifoLevel != '0;
   assign sideRead = rxHoldingRegRead | modemStatusRegRead | lineStatusRegRead;
   assign expire = (count_q >= limit) && (limit != 16'h0000);

   // Original mode counts only while data waits; periodic mode runs freely.
   assign count_d = (rxCharStrobe || expire
                     || (!periodicMode && !dataWaiting)) ? 16'h0000
                    : count_q + 16'h0001;

   // Expiry sets the flag in periodic mode or while data waits, set beats clear; a side read or ident read clears.
   // A side read models the silicon hazard of clearing the flag.
   assign irq_d = (expire && (periodicMode || dataWaiting)) ? 1'b1
                  : (irqIdentRegRead || sideRead) ? 1'b0
                  : irq_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         count_q <= 16'h0000;
         irq_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         irq_q <= irq_d;
      end
   end
   assign rxTimeoutIrq = irq_q;

   // Trigger compare shared by both directions of the DMA path.
   function automatic logic trigger_reached(
      input logic [FIFO_CNT_W-1:0] fill,
      input logic [5:0] trig
   );
      trigger_reached = (trig != 6'h00) && (fill >= FIFO_CNT_W'(trig));
   endfunction : trigger_reached

   // Index 0 is the receive direction and index 1 the transmit one.
   assign fillPair = {txFifoSpace, rxFifoLevel};
   assign trigPair = {txTriggerLevel, rxTriggerLevel};

   // Requests follow the level as programmed, power of two or not.
   generate
      for (genvar g = 0; g < 2; g++)
      begin : gen_dma
         logic req_q;
         assign dmaRawVec[g] = trigger_reached(
            fillPair[g*FIFO_CNT_W +: FIFO_CNT_W], trigPair[g*6 +: 6]);
         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               req_q <= 1'b0;
            end
            else
            begin
               req_q <= dmaRawVec[g];
            end
         end
         assign dmaReqVec[g] = req_q;
      end
   endgenerate
   assign rxDmaReq = dmaReqVec[0];
   assign txDmaReq = dmaReqVec[1];

   // Cycles that pending data has waited with the timeout flag low.
   logic [16:0] starve_q;
   logic [15:0] limitSeen_q;
   logic starveReset;
   assign starveReset = rxTimeoutIrq || !dataWaiting || rxCharStrobe
                        || (limit == 16'h0000) || (limit != limitSeen_q);
   always_ff @(posedge clk)
   begin
      if (!nrst || starveReset)
      begin
         starve_q <= 17'h00000;
      end
      else
      begin
         starve_q <= starve_q + 17'h00001;
      end
   end
   always_ff @(posedge clk)
   begin
      limitSeen_q <= limit;
   end

   ident_clears_a: assert property (
      @(posedge clk) disable iff (!nrst)
      irqIdentRegRead && !expire |=> !rxTimeoutIrq)
      else $error("ident read did not clear timeout");
   expire_sets_a: assert property (
      @(posedge clk) disable iff (!nrst)
      expire && periodicMode |=> rxTimeoutIrq)
      else $error("periodic event did not raise timeout");
   data_retrig_a: assert property (
      @(posedge clk) disable iff (!nrst)
      count_q == limit && limit != 16'h0000 && dataWaiting
      |=> rxTimeoutIrq)
      else $error("pending data did not retrigger");
   char_resets_a: assert property (
      @(posedge clk) disable iff (!nrst)
      rxCharStrobe |=> count_q == 16'h0000)
      else $error("character did not restart count");
   idle_hold_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !periodicMode && !dataWaiting && !irqIdentRegRead && !sideRead
      |=> rxTimeoutIrq == $past(rxTimeoutIrq))
      else $error("timeout changed with empty fifo");
   side_read_a: assert property (
      @(posedge clk) disable iff (!nrst)
      sideRead && !expire |=> !rxTimeoutIrq)
      else $error("side read effect missing");
   hold_read_a: assert property (
      @(posedge clk) disable iff (!nrst)
      rxHoldingRegRead && !expire |=> !rxTimeoutIrq)
      else $error("holding read did not clear timeout");
   modem_read_a: assert property (
      @(posedge clk) disable iff (!nrst)
      modemStatusRegRead && !expire |=> !rxTimeoutIrq)
      else $error("modem read did not clear timeout");
   line_read_a: assert property (
      @(posedge clk) disable iff (!nrst)
      lineStatusRegRead && !expire |=> !rxTimeoutIrq)
      else $error("line read did not clear timeout");
   limit_len_a: assert property (
      @(posedge clk) disable iff (!nrst)
      limit != 16'h0000 && limit == $past(limit) |-> count_q <= limit)
      else $error("count passed programmed limit");
   zero_limit_a: assert property (
      @(posedge clk) disable iff (!nrst)
      limit == 16'h0000 && !rxTimeoutIrq |=> !rxTimeoutIrq)
      else $error("zero limit raised timeout");
   periodic_count_a: assert property (
      @(posedge clk) disable iff (!nrst)
      extFeatureRegTwo[uart_rx_timeout_pkg::PERIODIC_BIT] && !rxCharStrobe
      && !expire |=> count_q == $past(count_q) + 16'h0001)
      else $error("periodic mode did not count freely");
   empty_count_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !extFeatureRegTwo[uart_rx_timeout_pkg::PERIODIC_BIT] && !dataWaiting
      |=> count_q == 16'h0000)
      else $error("count ran with empty fifo");
   expire_restart_a: assert property (
      @(posedge clk) disable iff (!nrst)
      expire |=> count_q == 16'h0000)
      else $error("count did not restart after event");
   irq_holds_a: assert property (
      @(posedge clk) disable iff (!nrst)
      rxTimeoutIrq && !irqIdentRegRead && !sideRead |=> rxTimeoutIrq)
      else $error("timeout dropped without a read");
   no_false_raise_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !rxTimeoutIrq && !expire |=> !rxTimeoutIrq)
      else $error("timeout rose without an event");
   data_waits_a: assert property (
      @(posedge clk) disable iff (!nrst)
      starve_q <= {1'b0, limit} + 17'h00002)
      else $error("pending data never timed out");
   rx_dma_a: assert property (
      @(posedge clk) disable iff (!nrst)
      rxTriggerLevel != 6'h00 && rxFifoLevel >= FIFO_CNT_W'(rxTriggerLevel)
      |=> rxDmaReq)
      else $error("rx dma request missing");
   rx_dma_low_a: assert property (
      @(posedge clk) disable iff (!nrst)
      rxTriggerLevel == 6'h00 || rxFifoLevel < FIFO_CNT_W'(rxTriggerLevel)
      |=> !rxDmaReq)
      else $error("rx dma request too early");
   tx_dma_a: assert property (
      @(posedge clk) disable iff (!nrst)
      txTriggerLevel != 6'h00 && txFifoSpace >= FIFO_CNT_W'(txTriggerLevel)
      |=> txDmaReq)
      else $error("tx dma request missing");
   tx_dma_low_a: assert property (
      @(posedge clk) disable iff (!nrst)
      txTriggerLevel == 6'h00 || txFifoSpace < FIFO_CNT_W'(txTriggerLevel)
      |=> !txDmaReq)
      else $error("tx dma request too early");
endmodule : uart_rx_timeout

// file: testbench/rx_peer.sv
`timescale 1ns/1ns
module rx_peer (
   // Clock and control.
   input wire logic clk,
   input wire logic send,
   input wire logic drain,
   // Receive path state.
   output logic rxCharStrobe,
   output logic [6:0] rxFifoLevel
);
   initial rxCharStrobe = 1'b0;
   initial rxFifoLevel = 7'h00;
   // One character per request; the host empties the FIFO on drain.
   always @(posedge clk)
   begin
      rxCharStrobe <= send;
      rxFifoLevel <= drain ? 7'h00 : rxFifoLevel + {6'h00, send};
   end
endmodule : rx_peer

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0, nrst = 1'b0, send = 1'b0, drain = 1'b0, strobe;
   logic [7:0] efr = 8'h00, toH = 8'h00, toL = 8'h03;
   logic [5:0] rxTrig = 6'h04, txTrig = 6'h08;
   logic [6:0] txSpace = 7'h07, lvl;
   logic rdHold = 1'b0, rdModem = 1'b0, rdLine = 1'b0, rdIdent = 1'b0;
   logic irq, rxReq, txReq;
   int fails = 0, n_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         results();
      end
   end
   task chk(input string nm, input logic e, input logic s);
      n_checks++;
      if (s !== e)
      begin
         $display("mismatch %s exp %b got %b", nm, e, s);
         fails++;
      end
   endtask : chk
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task waitIrq(input logic e, input int n);
      for (int i = 0; i < n && irq !== e; i++) @(negedge clk);
      chk("rxTimeoutIrq", e, irq);
   endtask : waitIrq
   task t_orig;
      pulse(send);
      waitIrq(1'b1, 20);
      pulse(rdIdent);
      chk("rxTimeoutIrq", 1'b0, irq);
      waitIrq(1'b1, 20);
      pulse(rdLine);
      waitIrq(1'b0, 3);
      waitIrq(1'b1, 20);
      pulse(rdHold);
      chk("rxTimeoutIrq", 1'b0, irq);
      waitIrq(1'b1, 20);
      pulse(rdModem);
      chk("rxTimeoutIrq", 1'b0, irq);
      $display("test orig done");
   endtask : t_orig
   task t_per;
      pulse(drain);
      repeat (2) @(negedge clk);
      pulse(rdIdent);
      repeat (20) @(negedge clk);
      chk("rxTimeoutIrq", 1'b0, irq);
      efr = 8'h40;
      waitIrq(1'b1, 20);
      pulse(rdIdent);
      chk("rxTimeoutIrq", 1'b0, irq);
      waitIrq(1'b1, 20);
      toH = 8'hff;
      efr = 8'h40;
      pulse(rdIdent);
      efr = 8'h00;
      repeat (20) @(negedge clk);
      chk("rxTimeoutIrq", 1'b0, irq);
      $display("test periodic done");
   endtask : t_per
   task t_dma;
      send = 1'b1;
      repeat (3) @(negedge clk);
      send = 1'b0;
      repeat (2) @(negedge clk);
      chk("rxDmaReq", 1'b0, rxReq);
      pulse(send);
      repeat (2) @(negedge clk);
      chk("rxDmaReq", 1'b1, rxReq);
      chk("txDmaReq", 1'b0, txReq);
      txSpace = 7'h08;
      repeat (2) @(negedge clk);
      chk("txDmaReq", 1'b1, txReq);
      $display("test dma done");
   endtask : t_dma
   task results;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   rx_peer rx_peer_i (.clk(clk), .send(send), .drain(drain),
      .rxCharStrobe(strobe), .rxFifoLevel(lvl));
   uart_rx_timeout uart_rx_timeout_i (.clk(clk), .nrst(nrst),
      .extFeatureRegTwo(efr), .timeoutCountHigh(toH), .timeoutCountLow(toL),
      .rxTriggerLevel(rxTrig), .txTriggerLevel(txTrig),
      .rxCharStrobe(strobe), .rxFifoLevel(lvl), .txFifoSpace(txSpace),
      .rxHoldingRegRead(rdHold), .modemStatusRegRead(rdModem),
      .lineStatusRegRead(rdLine), .irqIdentRegRead(rdIdent),
      .rxTimeoutIrq(irq), .rxDmaReq(rxReq), .txDmaReq(txReq));
   initial
   begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      t_orig();
      t_per();
      t_dma();
      results();
   end
endmodule : tb
